// ===== snd_buzzer_model.sv
`timescale 1ns/100ps
// Piezo element: measures the time between drive edges, as the membrane would follow them
module snd_buzzer_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        drive_in,
   output logic      [15:0] half_len_out,
   output logic      [15:0] edges_out
);
   logic [15:0] run_q;
   logic        last_q;

   always_ff @(posedge clk_in) begin
      last_q <= drive_in;
      if (rst_in) begin
         run_q <= 16'h0000;
         edges_out <= 16'h0000;
         half_len_out <= 16'h0000;
      end else if (drive_in != last_q) begin
         half_len_out <= run_q + 16'h0001;
         run_q <= 16'h0000;
         edges_out <= edges_out + 16'h0001;
      end else begin
         run_q <= run_q + 16'h0001;
      end
   end
endmodule

// ===== snd_pkg.sv
package snd_pkg;

   typedef enum logic [1:0] {
      SND_IDLE = 2'h0,
      SND_PLAY = 2'h1,
      SND_GAP  = 2'h3
   } snd_seq_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic        slow_m;
      logic        slow_s;
      logic        slow_p;
      logic [7:0]  unit_cnt;
      logic [4:0]  pre_cnt;
      logic [11:0] pitch_a;
      logic [11:0] pitch_b;
      logic [7:0]  len_a;
      logic [7:0]  len_b;
      logic [7:0]  gap_a;
      logic [7:0]  gap_b;
      logic [7:0]  hold_len;
      logic        enable;
      logic        invert;
      logic        ien_b;
      logic        ien_a;
      logic        flag_b;
      logic        flag_a;
      logic        go_b;
      logic        go_a;
      logic [1:0]  tu_sel;
      logic        prescale_sel;
      logic        hold_ien;
      logic        hold_flag;
      logic        hold_run;
      logic [7:0]  hold_cnt;
      snd_seq_t    seq;
      logic        cur_b;
      logic [7:0]  dur_cnt;
      logic [11:0] tone_cnt;
      logic        tone_lvl;
      logic        out;
   } snd_state_t;

endpackage

// ===== snd_tone_consts.svh
`ifndef SND_TONE_CONSTS_SVH
`define SND_TONE_CONSTS_SVH

// Register indices; byte address is four times the index
`define SND_IDX_PITCH_A_LO   16'ha040
`define SND_IDX_PITCH_A_HI   16'ha041
`define SND_IDX_LEN_A        16'ha042
`define SND_IDX_GAP_A        16'ha043
`define SND_IDX_PITCH_B_LO   16'ha044
`define SND_IDX_PITCH_B_HI   16'ha045
`define SND_IDX_LEN_B        16'ha046
`define SND_IDX_GAP_B        16'ha047
`define SND_IDX_CONFIG       16'ha048
`define SND_IDX_HOLD_LEN     16'ha049
`define SND_IDX_UNIT_CTRL    16'ha04a

// sounder_config fields
`define SND_CFG_ENABLE       7
`define SND_CFG_INVERT       6
`define SND_CFG_IEN_B        5
`define SND_CFG_IEN_A        4
`define SND_CFG_FLAG_B       3
`define SND_CFG_FLAG_A       2
`define SND_CFG_GO_B         1
`define SND_CFG_GO_A         0

// note_time_unit_control fields
`define SND_TU_SEL_HI        7
`define SND_TU_SEL_LO        6
`define SND_TU_PRESCALE      4
`define SND_TU_HOLD_IEN      1
`define SND_TU_HOLD_FLAG     0

`define SND_RESET_BYTE       8'h00

// Time unit base: 1 ms of the slow reference
`define SND_SLOW_HZ          32000
`define SND_UNIT_US          1000
`define SND_UNIT_TICKS       9'((`SND_SLOW_HZ * `SND_UNIT_US) / 1000000)

// Tone base dividers; the pitch counter toggles, so it runs at twice the base
`define SND_BASE_DIV_LO      32
`define SND_BASE_DIV_HI      64
`define SND_HALF_LIM_LO      5'((`SND_BASE_DIV_LO / 2) - 1)
`define SND_HALF_LIM_HI      5'((`SND_BASE_DIV_HI / 2) - 1)

`endif

// ===== snd_tone_gen.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "snd_tone_consts.svh"

// Function
// - Two-bit unit select gives 1, 2, 4 or 8 ms steps for all timers.
// - Time unit ticks come from the slow reference only, never the tone path.
// - Prescale bit picks system clock divided by 32 or by 64 as tone base.
// - Hold timer expiry sets a sticky flag that only software clears.
// - Hold interrupt asserts only while its enable bit is one.
// - Config bit 7 enables the whole sounder; zero disables it.
// - Invert bit flips the sounder output pin polarity.
// - Note B end sets its flag only when its enable is set, raising interrupt.
// - Note A end sets its flag only when its enable is set, raising interrupt.
// - Writing one to note B go starts note B; writing zero does nothing.
// - Writing one to note A go starts note A; writing zero does nothing.
// - Each go bit clears itself when its note completes.
// - Both go bits set together play note A first, then note B.
// - Playing status reads one while that note plays or pauses, sharing go bit positions.
// - Tone frequency is base clock divided by pitch divider plus one.
// - Play length is length value times unit; pause is gap value times unit.
// - Hold timer restarts on each write of a one to a go bit, not when a queued note B starts, expiring after length times unit.
// - Notes play once each, in sequence, then the sounder goes idle.
module snd_tone_gen (
   input  wire logic        clk_sys_in,
   input  wire logic        arst_n_in,
   input  wire logic        slow_ref_clock_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [17:0] wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   output logic             sounder_output_out,
   output logic             supply_hold_timer_out,
   output logic             note_irq_out,
   output logic             hold_timer_irq_out
);

   logic                rst_m_q;
   logic                rst_n_q;
   snd_pkg::snd_state_t s_q;
   snd_pkg::snd_state_t s_d;

   function automatic logic idx_hit(input logic [15:0] idx, input logic [15:0] want);
      idx_hit = (idx == want);
   endfunction

   // Shared down-count step for the hold and length timers
   function automatic logic [7:0] dec8(input logic [7:0] cnt);
      dec8 = 8'(cnt - 8'h01);
   endfunction

   // Busy spans play and pause, so software sees one busy window per note
   function automatic logic note_busy(input snd_pkg::snd_seq_t seq,
                                      input logic              cur_b,
                                      input logic              want_b);
      note_busy = (seq != snd_pkg::SND_IDLE) && (cur_b == want_b);
   endfunction

   // Reset release is synchronised; assertion stays asynchronous
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   always_comb begin
      logic [15:0] idx;
      logic        req;
      logic        wr;
      logic        lane0;
      logic [7:0]  wbyte;
      logic [7:0]  rbyte;
      logic        slow_edge;
      logic [8:0]  unit_lim;
      logic        unit_tick;
      logic [4:0]  pre_lim;
      logic        tone_tick;
      logic [11:0] div;
      logic        start;
      logic        done_a;
      logic        done_b;
      idx       = wb_adr_in[17:2];
      req       = wb_cyc_in & wb_stb_in;
      // Writes land on the edge that shows ack, where the master samples it
      wr        = req & wb_we_in & s_q.ack & wb_sel_in[0];
      lane0     = wb_sel_in[0];
      wbyte     = wb_dat_in[7:0];
      rbyte     = `SND_RESET_BYTE;
      start     = 1'b0;
      done_a    = 1'b0;
      done_b    = 1'b0;
      // Every local gets a value first so no path holds an old one
      slow_edge = 1'b0;
      unit_lim  = 9'h000;
      unit_tick = 1'b0;
      pre_lim   = 5'h00;
      tone_tick = 1'b0;
      div       = 12'h000;

      s_d       = s_q;

      // Slow reference crosses in through two flops; edge taken after them
      s_d.slow_m = slow_ref_clock_in;
      s_d.slow_s = s_q.slow_m;
      s_d.slow_p = s_q.slow_s;
      slow_edge  = s_q.slow_s & ~s_q.slow_p;

      unit_lim  = 9'((`SND_UNIT_TICKS << s_q.tu_sel) - 9'h001);
      // Free-running count: a note's first unit may be up to one unit short
      // slow reference tick
      unit_tick = slow_edge && (s_q.unit_cnt == unit_lim[7:0]);
      if (slow_edge) begin
         s_d.unit_cnt = unit_tick ? 8'h00 : 8'(s_q.unit_cnt + 8'h01);
      end

      pre_lim   = s_q.prescale_sel ? `SND_HALF_LIM_HI : `SND_HALF_LIM_LO;
      tone_tick = (s_q.pre_cnt == pre_lim);
      s_d.pre_cnt = tone_tick ? 5'h00 : 5'(s_q.pre_cnt + 5'h01);

      // Ack is registered, so reads see one cycle of decode time
      s_d.ack = req & ~s_q.ack;

      if (wr) begin
         case (1'b1)
            idx_hit(idx, `SND_IDX_PITCH_A_LO): s_d.pitch_a[7:0]  = wbyte;
            idx_hit(idx, `SND_IDX_PITCH_A_HI): s_d.pitch_a[11:8] = wbyte[3:0];
            idx_hit(idx, `SND_IDX_LEN_A):      s_d.len_a         = wbyte;
            idx_hit(idx, `SND_IDX_GAP_A):      s_d.gap_a         = wbyte;
            idx_hit(idx, `SND_IDX_PITCH_B_LO): s_d.pitch_b[7:0]  = wbyte;
            idx_hit(idx, `SND_IDX_PITCH_B_HI): s_d.pitch_b[11:8] = wbyte[3:0];
            idx_hit(idx, `SND_IDX_LEN_B):      s_d.len_b         = wbyte;
            idx_hit(idx, `SND_IDX_GAP_B):      s_d.gap_b         = wbyte;
            idx_hit(idx, `SND_IDX_HOLD_LEN):   s_d.hold_len      = wbyte;
            idx_hit(idx, `SND_IDX_CONFIG): begin
               s_d.enable = wbyte[`SND_CFG_ENABLE];
               s_d.invert = wbyte[`SND_CFG_INVERT];
               s_d.ien_b  = wbyte[`SND_CFG_IEN_B];
               s_d.ien_a  = wbyte[`SND_CFG_IEN_A];
               if (!wbyte[`SND_CFG_FLAG_B]) begin
                  s_d.flag_b = 1'b0;
               end
               if (!wbyte[`SND_CFG_FLAG_A]) begin
                  s_d.flag_a = 1'b0;
               end
               if (s_q.enable) begin
                  if (wbyte[`SND_CFG_GO_B]) begin
                     s_d.go_b = 1'b1;
                     start    = 1'b1;
                  end
                  if (wbyte[`SND_CFG_GO_A]) begin
                     s_d.go_a = 1'b1;
                     start    = 1'b1;
                  end
               end
            end
            idx_hit(idx, `SND_IDX_UNIT_CTRL): begin
               s_d.tu_sel       = wbyte[`SND_TU_SEL_HI:`SND_TU_SEL_LO];
               s_d.prescale_sel = wbyte[`SND_TU_PRESCALE];
               s_d.hold_ien     = wbyte[`SND_TU_HOLD_IEN];
               if (!wbyte[`SND_TU_HOLD_FLAG]) begin
                  s_d.hold_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Read data is captured when ack rises and held until the master takes it
      case (1'b1)
         idx_hit(idx, `SND_IDX_PITCH_A_LO): rbyte = s_q.pitch_a[7:0];
         idx_hit(idx, `SND_IDX_PITCH_A_HI): rbyte = {4'h0, s_q.pitch_a[11:8]};
         idx_hit(idx, `SND_IDX_LEN_A):      rbyte = s_q.len_a;
         idx_hit(idx, `SND_IDX_GAP_A):      rbyte = s_q.gap_a;
         idx_hit(idx, `SND_IDX_PITCH_B_LO): rbyte = s_q.pitch_b[7:0];
         idx_hit(idx, `SND_IDX_PITCH_B_HI): rbyte = {4'h0, s_q.pitch_b[11:8]};
         idx_hit(idx, `SND_IDX_LEN_B):      rbyte = s_q.len_b;
         idx_hit(idx, `SND_IDX_GAP_B):      rbyte = s_q.gap_b;
         idx_hit(idx, `SND_IDX_HOLD_LEN):   rbyte = s_q.hold_len;
         idx_hit(idx, `SND_IDX_CONFIG): begin
            rbyte = {s_q.enable, s_q.invert, s_q.ien_b, s_q.ien_a,
                     s_q.flag_b, s_q.flag_a,
                     note_busy(s_q.seq, s_q.cur_b, 1'b1),
                     note_busy(s_q.seq, s_q.cur_b, 1'b0)};
         end
         idx_hit(idx, `SND_IDX_UNIT_CTRL): begin
            rbyte = {s_q.tu_sel, 1'b0, s_q.prescale_sel, 2'h0, s_q.hold_ien, s_q.hold_flag};
         end
         default: rbyte = `SND_RESET_BYTE;
      endcase
      // Only lane 0 carries a register; the upper lanes always read zero
      if (req & ~s_q.ack & ~wb_we_in) begin
         s_d.rdat = lane0 ? {24'h00_0000, rbyte} : 32'h0000_0000;
      end

      if (start) begin
         s_d.hold_run = 1'b1;
         s_d.hold_cnt = s_q.hold_len;
      end else if (s_q.hold_run && unit_tick) begin
         // A length of zero or one expires on the first tick
         if (s_q.hold_cnt <= 8'h01) begin
            s_d.hold_run  = 1'b0;
            // sticky expiry flag, set wins over clear
            s_d.hold_flag = 1'b1;
         end else begin
            s_d.hold_cnt = dec8(s_q.hold_cnt);
         end
      end

      // One divider serves both notes; the note on the output picks the pitch
      div = s_q.cur_b ? s_q.pitch_b : s_q.pitch_a;
      case (s_q.seq)
         snd_pkg::SND_IDLE: begin
            s_d.tone_lvl = 1'b0;
            s_d.tone_cnt = 12'h000;
            // A before B when both wait
            // after A, a waiting B goes next
            if (s_q.go_b && (s_q.cur_b == 1'b0) && !s_q.go_a) begin
               s_d.cur_b   = 1'b1;
               s_d.dur_cnt = s_q.len_b;
               s_d.seq     = snd_pkg::SND_PLAY;
            end else if (s_q.go_a) begin
               s_d.cur_b   = 1'b0;
               s_d.dur_cnt = s_q.len_a;
               s_d.seq     = snd_pkg::SND_PLAY;
            end else if (s_q.go_b) begin
               s_d.cur_b   = 1'b1;
               s_d.dur_cnt = s_q.len_b;
               s_d.seq     = snd_pkg::SND_PLAY;
            end
         end
         snd_pkg::SND_PLAY: begin
            if (tone_tick) begin
               if (s_q.tone_cnt >= div) begin
                  s_d.tone_cnt = 12'h000;
                  s_d.tone_lvl = ~s_q.tone_lvl;
               end else begin
                  s_d.tone_cnt = 12'(s_q.tone_cnt + 12'h001);
               end
            end
            if (s_q.dur_cnt == 8'h00) begin
               s_d.seq      = snd_pkg::SND_GAP;
               s_d.dur_cnt  = s_q.cur_b ? s_q.gap_b : s_q.gap_a;
               s_d.tone_lvl = 1'b0;
            end else if (unit_tick) begin
               s_d.dur_cnt = dec8(s_q.dur_cnt);
            end
         end
         snd_pkg::SND_GAP: begin
            s_d.tone_lvl = 1'b0;
            if (s_q.dur_cnt == 8'h00) begin
               s_d.seq = snd_pkg::SND_IDLE;
               done_b  = s_q.cur_b;
               done_a  = ~s_q.cur_b;
            end else if (unit_tick) begin
               s_d.dur_cnt = dec8(s_q.dur_cnt);
            end
         end
         default: begin
            s_d.seq = snd_pkg::SND_IDLE;
         end
      endcase

      if (done_a) begin
         s_d.go_a = 1'b0;
      end
      if (done_b) begin
         s_d.go_b = 1'b0;
      end
      if (done_a && s_q.ien_a) begin
         s_d.flag_a = 1'b1;
      end
      if (done_b && s_q.ien_b) begin
         s_d.flag_b = 1'b1;
      end

      // Placed last so disable overrides every start and count path above, but not the flags
      // disabled block is held idle
      if (!s_q.enable) begin
         s_d.seq      = snd_pkg::SND_IDLE;
         s_d.go_a     = 1'b0;
         s_d.go_b     = 1'b0;
         s_d.hold_run = 1'b0;
         s_d.tone_lvl = 1'b0;
         s_d.tone_cnt = 12'h000;
         s_d.dur_cnt  = 8'h00;
         s_d.unit_cnt = 8'h00;
         s_d.pre_cnt  = 5'h00;
         s_d.hold_cnt = 8'h00;
         s_d.cur_b    = 1'b0;
      end

      s_d.out = s_d.tone_lvl ^ s_d.invert;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_out            = s_q.rdat;
   assign wb_ack_out            = s_q.ack;
   assign sounder_output_out    = s_q.out;
   assign supply_hold_timer_out = s_q.hold_run;
   assign note_irq_out          = s_q.flag_a | s_q.flag_b;
   assign hold_timer_irq_out    = s_q.hold_flag & s_q.hold_ien;

endmodule

// ===== snd_tone_gen_sva.sv
`timescale 1ns/100ps
module snd_tone_gen_sva (
   input  wire logic        clk_sys_in,
   input  wire logic        arst_n_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [31:0] wb_dat_out,
   input  wire logic        wb_ack_out,
   input  wire logic        sounder_output_out,
   input  wire logic        supply_hold_timer_out,
   input  wire logic        note_irq_out,
   input  wire logic        hold_timer_irq_out
);
   logic [3:0] since_wr_q;

   // Cycles since the last taken write; flags may only drop right after software touches them
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) since_wr_q <= 4'hf;
      else if (wb_ack_out && wb_we_in) since_wr_q <= 4'h0;
      else if (since_wr_q != 4'hf) since_wr_q <= since_wr_q + 4'h1;
   end

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   ack_latency_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("request not answered in one cycle");
   ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   rdat_upper_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   note_flag_hold_a: assert property (
      $fell(note_irq_out) |-> since_wr_q <= 4'h2) else $error("note flag cleared by hardware");
   hold_flag_hold_a: assert property (
      $fell(hold_timer_irq_out) |-> since_wr_q <= 4'h2) else $error("hold flag cleared by hardware");
   hold_start_a: assert property (
      $rose(supply_hold_timer_out) |-> since_wr_q <= 4'h3) else $error("hold timer started alone");
   hold_irq_cause_a: assert property (
      $rose(hold_timer_irq_out) && since_wr_q > 4'h2 |-> ##[0:2] !supply_hold_timer_out)
      else $error("hold interrupt without expiry");
   reset_idle_a: assert property (
      $rose(arst_n_in) |-> !sounder_output_out && !supply_hold_timer_out && !note_irq_out)
      else $error("outputs active after reset");
endmodule

bind snd_tone_gen snd_tone_gen_sva i_sva (
   .clk_sys_in            (clk_sys_in),
   .arst_n_in             (arst_n_in),
   .wb_cyc_in             (wb_cyc_in),
   .wb_stb_in             (wb_stb_in),
   .wb_we_in              (wb_we_in),
   .wb_dat_out            (wb_dat_out),
   .wb_ack_out            (wb_ack_out),
   .sounder_output_out    (sounder_output_out),
   .supply_hold_timer_out (supply_hold_timer_out),
   .note_irq_out          (note_irq_out),
   .hold_timer_irq_out    (hold_timer_irq_out)
);

// ===== snd_tone_gen_tb.sv
`timescale 1ns/100ps
`include "snd_tone_consts.svh"
module snd_tone_gen_tb;
   typedef struct packed {logic [15:0] idx; logic [7:0] wd; logic [7:0] rd;} snd_row_t;
   localparam logic [15:0] CFG = `SND_IDX_CONFIG;
   localparam logic [15:0] TUC = `SND_IDX_UNIT_CTRL;
   logic        clk_sys_in, arst_n_in, slow_ref, cyc, stb, we, ack, snd, hold, nirq, hirq;
   logic [17:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [15:0] half_len, edges, e0;
   logic [7:0]  rd;
   int          n_mismatch, check_count, n;
   time         t0;
   snd_row_t    rows [11] = '{'{16'ha040, 8'ha5, 8'ha5}, '{16'ha041, 8'hff, 8'h0f},
      '{16'ha042, 8'h3c, 8'h3c}, '{16'ha043, 8'hc3, 8'hc3}, '{16'ha044, 8'h5a, 8'h5a},
      '{16'ha045, 8'hf3, 8'h03}, '{16'ha046, 8'h81, 8'h81}, '{16'ha047, 8'h7e, 8'h7e},
      '{16'ha049, 8'h99, 8'h99}, '{16'ha04a, 8'hff, 8'hd2}, '{16'ha04b, 8'hff, 8'h00}};

   snd_tone_gen i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .slow_ref_clock_in(slow_ref), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .sounder_output_out(snd), .supply_hold_timer_out(hold), .note_irq_out(nirq),
      .hold_timer_irq_out(hirq));
   snd_buzzer_model i_buz (.clk_in(clk_sys_in), .rst_in(!arst_n_in), .drive_in(snd),
      .half_len_out(half_len), .edges_out(edges));

   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   // Slow reference sped up so one time unit is 256 system cycles
   initial begin
      slow_ref = 1'b0;
      #3;
      forever #32 slow_ref = ~slow_ref;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic fail_on(input logic bad);
      if (bad) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
      int k;
      k = 0;
      @(posedge clk_sys_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h00_0000, wd};
      do begin
         @(posedge clk_sys_in);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rd = rdat[7:0];
      fail_on(ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(16'(rd), 16'(exp));
   endtask
   task automatic all_zero();
      for (int i = 0; i < 11; i++) rchk(16'ha040 + 16'(i), 8'h00);
   endtask
   task automatic wait_tone();
      e0 = edges;
      for (n = 0; n < 500 && edges < e0 + 16'h0003; n++) @(posedge clk_sys_in);
      fail_on(n >= 500);
   endtask
   task automatic wait_irq();
      for (n = 0; n < 3000 && nirq !== 1'b1; n++) @(posedge clk_sys_in);
      fail_on(n >= 3000);
   endtask

   initial begin
      arst_n_in = 1'b0;
      {cyc, stb, we} = 3'h0;
      adr = 18'h0_0000;
      sel = 4'h1;
      wdat = 32'h0000_0000;
      {n_mismatch, check_count} = 0;
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      all_zero();
      for (int i = 0; i < 11; i++) begin
         wb(1'b1, rows[i].idx, rows[i].wd);
         rchk(rows[i].idx, rows[i].rd);
      end
      $display("register table done");
      foreach (rows[i]) if (i < 5) wb(1'b1, 16'ha040 + 16'(i), (i == 2) ? 8'h03 : 8'h01);
      wb(1'b1, 16'ha041, 8'h00);
      wb(1'b1, 16'ha049, 8'h02);
      wb(1'b1, TUC, 8'h02);
      wb(1'b1, CFG, 8'h90);
      wb(1'b1, CFG, 8'h91);
      t0 = $time;
      rchk(CFG, 8'h91);
      chk(16'(hold), 16'h0001);
      wait_tone();
      chk(half_len, 16'h0020);
      wait_irq();
      chk(16'(($time - t0) / 8 >= 768 && ($time - t0) / 8 <= 1320), 16'h0001);
      chk(16'(snd), 16'h0000);
      chk({14'h0000, hirq, hold}, 16'h0002);
      rchk(CFG, 8'h94);
      rchk(TUC, 8'h03);
      $display("note a done");
      wb(1'b1, TUC, 8'h50);
      rchk(TUC, 8'h50);
      wb(1'b1, 16'ha044, 8'h00);
      wb(1'b1, 16'ha045, 8'h00);
      wb(1'b1, 16'ha046, 8'h03);
      wb(1'b1, 16'ha047, 8'h00);
      wb(1'b1, CFG, 8'hc0);
      repeat (3) @(posedge clk_sys_in);
      chk(16'(snd), 16'h0001);
      wb(1'b1, CFG, 8'hc2);
      t0 = $time;
      rchk(CFG, 8'hc2);
      wait_tone();
      chk(half_len, 16'h0020);
      rd = 8'h02;
      for (n = 0; n < 1000 && rd[1] !== 1'b0; n++) wb(1'b0, CFG, 8'h00);
      fail_on(n >= 1000);
      chk(16'(($time - t0) / 8 >= 1024 && ($time - t0) / 8 <= 2088), 16'h0001);
      chk(16'(rd), 16'h00c0);
      $display("note b done");
      wb(1'b1, TUC, 8'h10);
      wb(1'b1, CFG, 8'hb3);
      t0 = $time;
      rchk(CFG, 8'hb1);
      wait_irq();
      chk(16'(($time - t0) / 8 >= 768 && ($time - t0) / 8 <= 1320), 16'h0001);
      rchk(CFG, 8'hb6);
      wb(1'b1, CFG, 8'hb0);
      rchk(CFG, 8'hb2);
      wait_irq();
      rchk(CFG, 8'hb8);
      $display("pair done");
      wb(1'b1, CFG, 8'h00);
      wb(1'b1, CFG, 8'h01);
      rchk(CFG, 8'h00);
      wb(1'b1, CFG, 8'h81);
      rchk(CFG, 8'h80);
      wb(1'b1, CFG, 8'h91);
      wb(1'b1, CFG, 8'h10);
      repeat (300) @(posedge clk_sys_in);
      rchk(CFG, 8'h10);
      chk({14'h0000, snd, hold}, 16'h0000);
      $display("disable done");
      wb(1'b1, CFG, 8'h91);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      all_zero();
      $display("reset done");
      wrap_up();
   end
endmodule
